/* File: verilog/fsmc_regs.vh */
// constants for the fail-safe mode controller
`ifndef FSMC_REGS_VH
`define FSMC_REGS_VH
// mode codes
`define FSMC_ST_STARTUP 3'h0
`define FSMC_ST_RESTART 3'h1
`define FSMC_ST_FAILSAFE 3'h2
`define FSMC_ST_NORMAL 3'h3
`define FSMC_ST_STANDBY 3'h4
`define FSMC_ST_FLASH 3'h5
`define FSMC_ST_FSWAIT 3'h6
// reset source codes
`define FSMC_SRC_POWERON 4'h0
`define FSMC_SRC_WAKE 4'h1
`define FSMC_SRC_WDOG 4'h2
`define FSMC_SRC_INTTO 4'h3
`define FSMC_SRC_INIT 4'h4
`define FSMC_SRC_CURRENT 4'h5
`define FSMC_SRC_FAILSAFE 4'h6
// times in microseconds
`define FSMC_RST_SHORT_US 1
`define FSMC_RST_LONG_US 20
`define FSMC_INT_LIMIT_US 256
`define FSMC_RET_DELAY_US 100
`define FSMC_WD_INIT_US 256
// clock rate in MHz
`define FSMC_CLK_MHZ 200
`endif

/* File: verilog/fsmc_sync.v */
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module fsmc_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // fsmc_sync

/* File: verilog/fsmc_timer.v */
// down counter with load and done flag
`timescale 1ns/100ps
module fsmc_timer #(
  parameter WIDTH = 24
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // control
  input wire load,
  input wire [WIDTH-1:0] load_val,
  input wire run,
  output wire done,
  output wire [WIDTH-1:0] count
);
  reg [WIDTH-1:0] cnt_q;
  always @(posedge core_clk)
  begin
    if (sys_rst)
      cnt_q <= {WIDTH{1'b0}};
    else if (load)
      cnt_q <= load_val;
    else if (run && cnt_q != {WIDTH{1'b0}})
      cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
  end
  assign done = (cnt_q == {WIDTH{1'b0}});
  assign count = cnt_q;
endmodule // fsmc_timer

/* File: verilog/fsmc_mode_ctrl.v */
// operating mode state machine of the fail-safe controller
// Function
// - start-up on power-on and reset, source recorded
// - bus or wake-pin wake-up enters start-up
// - start-up holds reset low for stretch time
// - then watchdog init: normal/flash, else restart
// - restart mode forces long reset stretch
// - restart success only normal; failure fail-safe
// - severe faults or restart failure: fail-safe
// - leave fail-safe on wake with oscillator ok
// - fail-safe exit: delay, supply on, long reset
// - normal: window watchdog, reset when unserved
// - normal: unanswered interrupt causes reset
// - bus transceiver only on enable bit
// - standby: time-out watchdog unless off option
// - watchdog off only below low current
// - current high restarts watchdog, miss resets
// - off from normal uses maximum period
// - off in standby uses last period
// - overflow select chooses irq, auto-cleared
// - interrupt read within limit or reset
// - standby wake sources by irq or reset
// - slow or stopped oscillator: fail-safe
// - window trigger only between half and full
`timescale 1ns/100ps
`include "fsmc_regs.vh"
module fsmc_mode_ctrl #(
  parameter TW = 24,
  parameter RST_SHORT = `FSMC_RST_SHORT_US * `FSMC_CLK_MHZ,
  parameter RST_LONG = `FSMC_RST_LONG_US * `FSMC_CLK_MHZ,
  parameter INT_LIMIT = `FSMC_INT_LIMIT_US * `FSMC_CLK_MHZ,
  parameter RET_DELAY = `FSMC_RET_DELAY_US * `FSMC_CLK_MHZ,
  parameter WD_INIT = `FSMC_WD_INIT_US * `FSMC_CLK_MHZ,
  parameter [TW-1:0] WD_MAX = 24'hffffff
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // pins from outside, synchronised here
  input wire bus_wake_pin,
  input wire local_wake_pin,
  input wire osc_fail_pin,
  input wire severe_fault_pin,
  input wire cur_low_pin,
  input wire cur_high_pin,
  input wire supply_fail_pin,
  // host commands, core clock domain
  input wire wd_trigger,
  input wire [TW-1:0] wd_period,
  input wire mode_req_valid,
  input wire [2:0] mode_req,
  input wire reset_length_select,
  input wire bus_transceiver_enable,
  input wire wd_off_select,
  input wire overflow_interrupt_select_set,
  input wire int_event,
  input wire int_reg_read,
  // outputs
  output wire system_reset_output_low,
  output wire mcu_supply_regulator,
  output wire bus_transceiver_on,
  output wire overflow_interrupt_select,
  output wire wake_irq,
  output wire wd_running,
  output wire [2:0] mode,
  output wire [3:0] reset_source
);
  wire [6:0] pins_s;
  wire bus_wake;
  wire wake_pin;
  wire osc_fail;
  wire severe;
  wire cur_low;
  wire cur_high;
  wire sup_fail;
  reg [2:0] st_q, st_d;
  reg [3:0] src_q, src_d;
  reg long_q, long_d;
  reg rst_low_q, rst_low_d;
  reg init_wait_q, init_wait_d;
  reg boot_q, boot_d;
  reg ovf_sel_q, ovf_sel_d;
  reg wd_off_q, wd_off_d;
  reg wd_draining_q, wd_draining_d;
  reg [TW-1:0] last_per_q, last_per_d;
  reg int_pend_q, int_pend_d;
  reg wake_irq_q, wake_irq_d;
  reg wake_prev_q;
  reg ld;
  reg [TW-1:0] ld_val;
  reg ld_i;
  wire t_done, i_done;
  wire [TW-1:0] t_cnt;
  wire wake_fall;
  wire any_wake;
  reg go_reset;
  reg [3:0] go_src;

  fsmc_sync #(.WIDTH(7)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({bus_wake_pin, local_wake_pin, osc_fail_pin,
      severe_fault_pin, cur_low_pin, cur_high_pin, supply_fail_pin}),
    .sync_out(pins_s)
  );
  assign {bus_wake, wake_pin, osc_fail, severe, cur_low, cur_high,
    sup_fail} = pins_s;

  // one timer serves reset, init, watchdog and restart delay
  fsmc_timer #(.WIDTH(TW)) u_tmr (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(ld),
    .load_val(ld_val),
    .run(1'b1),
    .done(t_done),
    .count(t_cnt)
  );
  fsmc_timer #(.WIDTH(TW)) u_int_tmr (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(ld_i),
    .load_val(INT_LIMIT[TW-1:0]),
    .run(int_pend_q),
    .done(i_done),
    .count()
  );

  assign wake_fall = wake_prev_q & ~wake_pin;
  assign any_wake = bus_wake | wake_fall;

  // trigger accepted only in second half of period
  function early_trig;
    input [TW-1:0] remain;
    input [TW-1:0] per;
    begin
      early_trig = (remain > {1'b0, per[TW-1:1]});
    end
  endfunction

  always @*
  begin
    st_d = st_q;
    src_d = src_q;
    long_d = long_q;
    rst_low_d = rst_low_q;
    init_wait_d = init_wait_q;
    boot_d = 1'b0;
    ovf_sel_d = ovf_sel_q | overflow_interrupt_select_set;
    wd_off_d = wd_off_q;
    wd_draining_d = wd_draining_q;
    last_per_d = last_per_q;
    int_pend_d = int_pend_q;
    wake_irq_d = 1'b0;
    ld = 1'b0;
    ld_val = wd_period;
    ld_i = 1'b0;
    go_reset = 1'b0;
    go_src = `FSMC_SRC_WDOG;
    if (int_event && !int_pend_q)
    begin
      int_pend_d = 1'b1;
      ld_i = 1'b1;
    end
    else if (int_reg_read)
      int_pend_d = 1'b0;
    case (st_q)
      `FSMC_ST_STARTUP, `FSMC_ST_RESTART:
      begin
        if (rst_low_q)
        begin
          // timer still empty in the cycle after sys_rst
          if (t_done && !boot_q)
          begin
            rst_low_d = 1'b0;
            init_wait_d = 1'b1;
            ld = 1'b1;
            ld_val = WD_INIT[TW-1:0];
          end
        end
        else if (init_wait_q)
        begin
          if (mode_req_valid && (mode_req == `FSMC_ST_NORMAL ||
              (mode_req == `FSMC_ST_FLASH && st_q == `FSMC_ST_STARTUP)))
          begin
            init_wait_d = 1'b0;
            st_d = mode_req;
            last_per_d = wd_period;
            ld = 1'b1;
          end
          else if (t_done || (st_q == `FSMC_ST_RESTART && sup_fail))
          begin
            init_wait_d = 1'b0;
            if (st_q == `FSMC_ST_RESTART)
            begin
              st_d = `FSMC_ST_FAILSAFE;
              rst_low_d = 1'b1;
            end
            else
            begin
              st_d = `FSMC_ST_RESTART;
              long_d = 1'b1;
              rst_low_d = 1'b1;
              src_d = `FSMC_SRC_INIT;
              ld = 1'b1;
              ld_val = RST_LONG[TW-1:0];
            end
          end
        end
      end
      `FSMC_ST_NORMAL:
      begin
        if (wd_trigger)
        begin
          if (early_trig(t_cnt, last_per_q))
            go_reset = 1'b1;
          else
          begin
            ld = 1'b1;
            last_per_d = wd_period;
          end
        end
        else if (t_done)
          go_reset = 1'b1;
        else if (mode_req_valid && mode_req == `FSMC_ST_STANDBY)
        begin
          st_d = `FSMC_ST_STANDBY;
          wd_off_d = wd_off_select;
          wd_draining_d = wd_off_select;
          ld = 1'b1;
          ld_val = wd_off_select ? WD_MAX : wd_period;
          if (wd_off_select)
            last_per_d = WD_MAX;
        end
      end
      `FSMC_ST_STANDBY:
      begin
        if (wd_off_select && !wd_off_q)
        begin
          wd_off_d = 1'b1;
          wd_draining_d = 1'b1;
        end
        if (wd_off_q && !wd_draining_q)
        begin
          if (cur_high)
          begin
            wd_draining_d = 1'b1;
            wake_irq_d = 1'b1;
            ld = 1'b1;
            ld_val = last_per_q;
          end
        end
        else if (wd_trigger)
        begin
          ld = 1'b1;
          last_per_d = wd_period;
        end
        else if (t_done)
        begin
          if (wd_off_q && cur_low)
            wd_draining_d = 1'b0;
          else if (ovf_sel_q)
          begin
            wake_irq_d = 1'b1;
            ovf_sel_d = overflow_interrupt_select_set;
            ld = 1'b1;
            ld_val = last_per_q;
          end
          else
          begin
            go_reset = 1'b1;
            ovf_sel_d = 1'b0;
          end
        end
        if (any_wake)
          wake_irq_d = 1'b1;
        if (mode_req_valid && mode_req == `FSMC_ST_NORMAL)
        begin
          st_d = `FSMC_ST_NORMAL;
          wd_off_d = 1'b0;
          ld = 1'b1;
          last_per_d = wd_period;
        end
      end
      `FSMC_ST_FLASH:
      begin
        if (wd_trigger)
          ld = 1'b1;
        else if (t_done)
          go_reset = 1'b1;
      end
      `FSMC_ST_FAILSAFE:
      begin
        if (any_wake && !osc_fail)
        begin
          st_d = `FSMC_ST_FSWAIT;
          ld = 1'b1;
          ld_val = RET_DELAY[TW-1:0];
        end
      end
      `FSMC_ST_FSWAIT:
      begin
        if (t_done)
        begin
          st_d = `FSMC_ST_STARTUP;
          long_d = 1'b1;
          rst_low_d = 1'b1;
          src_d = `FSMC_SRC_FAILSAFE;
          ld = 1'b1;
          ld_val = RST_LONG[TW-1:0];
        end
      end
      default:
        st_d = `FSMC_ST_FAILSAFE;
    endcase
    // interrupt response supervision
    if (int_pend_q && i_done && !int_reg_read &&
        (st_q == `FSMC_ST_NORMAL || st_q == `FSMC_ST_STANDBY))
    begin
      go_reset = 1'b1;
      go_src = `FSMC_SRC_INTTO;
    end
    if (st_q == `FSMC_ST_STANDBY && any_wake && !ovf_sel_q)
    begin
      go_reset = 1'b1;
      go_src = `FSMC_SRC_WAKE;
    end
    if (go_reset)
    begin
      st_d = `FSMC_ST_STARTUP;
      src_d = go_src;
      rst_low_d = 1'b1;
      init_wait_d = 1'b0;
      int_pend_d = 1'b0;
      wd_off_d = 1'b0;
      ld = 1'b1;
      ld_val = (long_q | reset_length_select) ? RST_LONG[TW-1:0] :
        RST_SHORT[TW-1:0];
    end
    // first stretch after sys_rst
    if (boot_q)
    begin
      ld = 1'b1;
      ld_val = reset_length_select ? RST_LONG[TW-1:0] : RST_SHORT[TW-1:0];
    end
    // oscillator loss or severe fault wins over everything
    if (severe || osc_fail)
    begin
      st_d = `FSMC_ST_FAILSAFE;
      rst_low_d = 1'b1;
      init_wait_d = 1'b0;
      int_pend_d = 1'b0;
    end
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_q <= `FSMC_ST_STARTUP;
      src_q <= `FSMC_SRC_POWERON;
      long_q <= 1'b0;
      rst_low_q <= 1'b1;
      init_wait_q <= 1'b0;
      boot_q <= 1'b1;
      ovf_sel_q <= 1'b0;
      wd_off_q <= 1'b0;
      wd_draining_q <= 1'b0;
      last_per_q <= {TW{1'b0}};
      int_pend_q <= 1'b0;
      wake_irq_q <= 1'b0;
      wake_prev_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      src_q <= src_d;
      long_q <= long_d;
      rst_low_q <= rst_low_d;
      init_wait_q <= init_wait_d;
      boot_q <= boot_d;
      ovf_sel_q <= ovf_sel_d;
      wd_off_q <= wd_off_d;
      wd_draining_q <= wd_draining_d;
      last_per_q <= last_per_d;
      int_pend_q <= int_pend_d;
      wake_irq_q <= wake_irq_d;
      wake_prev_q <= wake_pin;
    end
  end

  assign system_reset_output_low = ~rst_low_q;
  // supply off only in fail-safe, discharged during restart delay
  assign mcu_supply_regulator = (st_q != `FSMC_ST_FAILSAFE) &&
    (st_q != `FSMC_ST_FSWAIT);
  assign bus_transceiver_on = (st_q == `FSMC_ST_NORMAL) &&
    bus_transceiver_enable;
  assign overflow_interrupt_select = ovf_sel_q;
  assign wake_irq = wake_irq_q;
  assign wd_running = !(wd_off_q && !wd_draining_q);
  assign mode = st_q;
  assign reset_source = src_q;
endmodule // fsmc_mode_ctrl

/* File: sim/fsmc_host_model.sv */
// host microcontroller model: start-up handshake and irq service
`timescale 1ns/100ps
`include "fsmc_regs.vh"
module fsmc_host_model (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // from the device
  input wire system_reset_output_low,
  input wire [2:0] mode,
  input wire wake_irq,
  // test control, low makes the host miss its start-up handshake
  input wire host_en,
  // to the device
  output reg hm_valid,
  output reg hm_read
);
  reg [3:0] dly_q;
  reg [2:0] irq_q;
  initial
  begin
    hm_valid = 1'b0;
    hm_read = 1'b0;
    dly_q = 4'h0;
    irq_q = 3'h0;
  end
  always @(posedge core_clk)
  begin
    // handshake a few cycles after reset release, start-up or restart
    if (sys_rst || !system_reset_output_low ||
        (mode != `FSMC_ST_STARTUP && mode != `FSMC_ST_RESTART))
      dly_q <= #1 4'h0;
    else if (dly_q != 4'hf)
      dly_q <= #1 dly_q + 4'h1;
    hm_valid <= #1 host_en && dly_q == 4'h4;
    // read the interrupt register well inside the limit
    irq_q <= #1 {irq_q[1:0], wake_irq};
    hm_read <= #1 irq_q[2];
  end
endmodule // fsmc_host_model

/* File: sim/fsmc_mode_ctrl_chk.sv */
// port assertions for the fail-safe mode controller
`timescale 1ns/100ps
`include "fsmc_regs.vh"
module fsmc_mode_ctrl_chk #(
  parameter RET_DELAY = 30
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // watched inputs
  input wire osc_fail_pin,
  input wire bus_transceiver_enable,
  // watched outputs
  input wire system_reset_output_low,
  input wire mcu_supply_regulator,
  input wire bus_transceiver_on,
  input wire wake_irq,
  input wire [2:0] mode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  reg [15:0] fw_cnt_q;
  // cycles spent in the restart delay
  always @(posedge core_clk)
  begin
    if (sys_rst || mode != `FSMC_ST_FSWAIT)
      fw_cnt_q <= 16'h0;
    else
      fw_cnt_q <= fw_cnt_q + 16'h1;
  end
  property p_fs_rst;
    mode == `FSMC_ST_FAILSAFE |-> !system_reset_output_low;
  endproperty
  a_fs_rst: assert property (p_fs_rst)
    else $error("reset high in fail-safe");
  property p_fs_sup;
    mode == `FSMC_ST_FAILSAFE |-> !mcu_supply_regulator;
  endproperty
  a_fs_sup: assert property (p_fs_sup)
    else $error("supply on in fail-safe");
  property p_xcvr;
    bus_transceiver_on ==
      (mode == `FSMC_ST_NORMAL && bus_transceiver_enable);
  endproperty
  a_xcvr: assert property (p_xcvr)
    else $error("transceiver state wrong");
  property p_norm_rst;
    mode == `FSMC_ST_NORMAL |-> system_reset_output_low;
  endproperty
  a_norm_rst: assert property (p_norm_rst)
    else $error("reset low in normal");
  property p_stretch;
    $fell(system_reset_output_low) |=> !system_reset_output_low [*8];
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("reset pulse too short");
  property p_osc;
    osc_fail_pin [*4] |-> ##[0:3] mode == `FSMC_ST_FAILSAFE;
  endproperty
  a_osc: assert property (p_osc)
    else $error("no fail-safe on oscillator fault");
  property p_fs_exit;
    mode == `FSMC_ST_FAILSAFE ##1 mode != `FSMC_ST_FAILSAFE
      |-> mode == `FSMC_ST_FSWAIT;
  endproperty
  a_fs_exit: assert property (p_fs_exit)
    else $error("fail-safe left without delay");
  property p_ret;
    mode == `FSMC_ST_FSWAIT ##1 mode == `FSMC_ST_STARTUP
      |-> fw_cnt_q >= RET_DELAY - 2;
  endproperty
  a_ret: assert property (p_ret)
    else $error("restart delay too short");
  property p_no_flash;
    mode == `FSMC_ST_RESTART |=> mode != `FSMC_ST_FLASH;
  endproperty
  a_no_flash: assert property (p_no_flash)
    else $error("flash entered from restart");
  c_normal: cover property (mode == `FSMC_ST_NORMAL);
  c_standby: cover property (mode == `FSMC_ST_STANDBY);
  c_fswait: cover property (mode == `FSMC_ST_FSWAIT);
  c_irq: cover property (wake_irq);
endmodule // fsmc_mode_ctrl_chk
bind fsmc_mode_ctrl fsmc_mode_ctrl_chk #(.RET_DELAY(RET_DELAY)) u_chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .osc_fail_pin(osc_fail_pin),
  .bus_transceiver_enable(bus_transceiver_enable),
  .system_reset_output_low(system_reset_output_low),
  .mcu_supply_regulator(mcu_supply_regulator),
  .bus_transceiver_on(bus_transceiver_on),
  .wake_irq(wake_irq),
  .mode(mode)
);

/* File: sim/test_fsmc_mode_ctrl.sv */
// self-checking testbench of the fail-safe mode controller
`timescale 1ns/100ps
`include "fsmc_regs.vh"
module test_fsmc_mode_ctrl;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg bus_wake_pin = 1'b0;
  reg local_wake_pin = 1'b0;
  reg osc_fail_pin = 1'b0;
  reg wd_trigger = 1'b0;
  reg [7:0] wd_period = 8'hc0;
  reg tb_v = 1'b0;
  reg [2:0] tb_m = 3'h0;
  reg rls = 1'b0;
  reg xen = 1'b0;
  reg ois_set = 1'b0;
  reg int_event = 1'b0;
  reg tb_rd = 1'b0;
  reg host_en = 1'b1;
  reg sev = 1'b0;
  reg cur_lo = 1'b0;
  reg cur_hi = 1'b0;
  reg sup_fail = 1'b0;
  reg wdo = 1'b0;
  wire hm_valid, hm_read, rst_n, sup, xon, ois, wake_irq, wdr;
  wire [2:0] mode;
  wire [3:0] src;
  integer num_errors = 0;
  integer compares = 0;
  integer n;
  always #2.5 core_clk = ~core_clk;
  // short counts keep the run brief
  fsmc_mode_ctrl #(.TW(8), .RST_SHORT(10), .RST_LONG(40),
    .INT_LIMIT(50), .RET_DELAY(30), .WD_INIT(60), .WD_MAX(8'hff)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .bus_wake_pin(bus_wake_pin), .local_wake_pin(local_wake_pin),
    .osc_fail_pin(osc_fail_pin), .severe_fault_pin(sev),
    .cur_low_pin(cur_lo), .cur_high_pin(cur_hi), .supply_fail_pin(sup_fail),
    .wd_trigger(wd_trigger), .wd_period(wd_period),
    .mode_req_valid(tb_v | hm_valid),
    .mode_req(tb_v ? tb_m : `FSMC_ST_NORMAL),
    .reset_length_select(rls), .bus_transceiver_enable(xen),
    .wd_off_select(wdo), .overflow_interrupt_select_set(ois_set),
    .int_event(int_event), .int_reg_read(tb_rd | hm_read),
    .system_reset_output_low(rst_n), .mcu_supply_regulator(sup),
    .bus_transceiver_on(xon), .overflow_interrupt_select(ois),
    .wake_irq(wake_irq), .wd_running(wdr), .mode(mode),
    .reset_source(src));
  fsmc_host_model u_host (.core_clk(core_clk), .sys_rst(sys_rst),
    .system_reset_output_low(rst_n), .mode(mode), .wake_irq(wake_irq),
    .host_en(host_en), .hm_valid(hm_valid), .hm_read(hm_read));
  task cyc(input integer k);
    begin
      repeat (k) @(posedge core_clk);
      #1;
    end
  endtask
  task summarize;
    begin
      $display("errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [3:0] e, input [3:0] g);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("unexpected %0s: expected %h, seen %h", nm, e, g);
      end
    end
  endtask
  // bounded wait for a mode; giving up ends the run
  task wait_mode(input [2:0] m, input integer lim);
    integer i;
    begin
      for (i = 0; i < lim && mode !== m; i = i + 1)
        cyc(1);
      chk("mode", {1'b0, m}, {1'b0, mode});
      if (mode !== m)
        summarize;
    end
  endtask
  // length of the next reset pulse in cycles
  task rst_len;
    integer i;
    begin
      n = 0;
      for (i = 0; i < 4 && rst_n === 1'b1; i = i + 1)
        cyc(1);
      while (rst_n === 1'b0 && n < 99)
      begin
        cyc(1);
        n = n + 1;
      end
    end
  endtask
  task pulse(input integer w);
    begin
      cyc(1);
      {wd_trigger, int_event, ois_set, tb_v} = 4'h0;
      bus_wake_pin = 1'b0;
      local_wake_pin = 1'b0;
      if (w > 1)
        cyc(w - 1);
    end
  endtask
  initial
  begin
    cyc(3);
    sys_rst = 1'b0;
    chk("mode", `FSMC_ST_STARTUP, {1'b0, mode});
    chk("src", `FSMC_SRC_POWERON, src);
    rst_len;
    chk("short", 4'h1, {3'h0, n >= 9 && n <= 12});
    wait_mode(`FSMC_ST_NORMAL, 100);
    chk("xcvr", 4'h0, {3'h0, xon});
    xen = 1'b1;
    cyc(1);
    chk("xcvr", 4'h1, {3'h0, xon});
    rls = 1'b1;
    wd_trigger = 1'b1;
    pulse(1);
    wait_mode(`FSMC_ST_STARTUP, 10);
    chk("src", `FSMC_SRC_WDOG, src);
    rst_len;
    chk("long", 4'h1, {3'h0, n >= 39});
    rls = 1'b0;
    wait_mode(`FSMC_ST_NORMAL, 200);
    cyc(150);
    wd_trigger = 1'b1;
    pulse(5);
    chk("mode", `FSMC_ST_NORMAL, {1'b0, mode});
    wait_mode(`FSMC_ST_STARTUP, 300);
    chk("src", `FSMC_SRC_WDOG, src);
    wait_mode(`FSMC_ST_NORMAL, 200);
    int_event = 1'b1;
    pulse(20);
    tb_rd = 1'b1;
    cyc(1);
    tb_rd = 1'b0;
    cyc(60);
    chk("mode", `FSMC_ST_NORMAL, {1'b0, mode});
    int_event = 1'b1;
    pulse(1);
    wait_mode(`FSMC_ST_STARTUP, 100);
    chk("src", `FSMC_SRC_INTTO, src);
    wait_mode(`FSMC_ST_NORMAL, 200);
    ois_set = 1'b1;
    tb_v = 1'b1;
    tb_m = `FSMC_ST_STANDBY;
    pulse(3);
    chk("mode", `FSMC_ST_STANDBY, {1'b0, mode});
    chk("ois", 4'h1, {3'h0, ois});
    for (n = 0; n < 400 && wake_irq !== 1'b1; n = n + 1)
      cyc(1);
    chk("irq", 4'h1, {3'h0, wake_irq});
    cyc(2);
    chk("ois", 4'h0, {3'h0, ois});
    chk("mode", `FSMC_ST_STANDBY, {1'b0, mode});
    wait_mode(`FSMC_ST_STARTUP, 400);
    chk("src", `FSMC_SRC_WDOG, src);
    wait_mode(`FSMC_ST_NORMAL, 200);
    tb_v = 1'b1;
    pulse(3);
    bus_wake_pin = 1'b1;
    pulse(1);
    wait_mode(`FSMC_ST_STARTUP, 20);
    chk("src", `FSMC_SRC_WAKE, src);
    host_en = 1'b0;
    wait_mode(`FSMC_ST_RESTART, 200);
    rst_len;
    chk("long", 4'h1, {3'h0, n >= 39});
    wait_mode(`FSMC_ST_FAILSAFE, 300);
    chk("sup", 4'h0, {3'h0, sup});
    host_en = 1'b1;
    bus_wake_pin = 1'b1;
    pulse(4);
    wait_mode(`FSMC_ST_FSWAIT, 20);
    wait_mode(`FSMC_ST_STARTUP, 100);
    chk("sup", 4'h1, {3'h0, sup});
    rst_len;
    chk("long", 4'h1, {3'h0, n >= 39});
    wait_mode(`FSMC_ST_NORMAL, 200);
    sev = 1'b1;
    wait_mode(`FSMC_ST_FAILSAFE, 10);
    chk("sup", 4'h0, {3'h0, sup});
    sev = 1'b0;
    cyc(4);
    bus_wake_pin = 1'b1;
    pulse(4);
    wait_mode(`FSMC_ST_FSWAIT, 20);
    wait_mode(`FSMC_ST_NORMAL, 300);
    osc_fail_pin = 1'b1;
    wait_mode(`FSMC_ST_FAILSAFE, 10);
    local_wake_pin = 1'b1;
    cyc(4);
    pulse(20);
    chk("mode", `FSMC_ST_FAILSAFE, {1'b0, mode});
    summarize;
  end
endmodule // test_fsmc_mode_ctrl
